// ### pkg/latch_pkg.sv
/*
  Constants shared by the set/reset latch unit: register offsets, field
  positions, reset values and divider encodings.
  Assumes a plain register port with byte-wide data and one clock.
*/
package latch_pkg;

  // register offsets on the plain register port
  localparam logic [0:0] MAIN_CONTROL_ADDR = 1'h0;
  localparam logic [0:0] SOURCE_SELECT_ADDR = 1'h1;

  // main control field positions
  localparam int LATCH_ENABLE_BIT = 7;
  localparam int DIVIDER_SEL_LSB = 4;
  localparam int TRUE_ROUTE_BIT = 3;
  localparam int INVERTED_ROUTE_BIT = 2;
  localparam int FW_SET_BIT = 1;
  localparam int FW_RESET_BIT = 0;

  // source select field positions
  localparam int PIN_SET_BIT = 7;
  localparam int CLOCK_SET_BIT = 6;
  localparam int COMP_B_SET_BIT = 5;
  localparam int COMP_A_SET_BIT = 4;
  localparam int PIN_RESET_BIT = 3;
  localparam int CLOCK_RESET_BIT = 2;
  localparam int COMP_B_RESET_BIT = 1;
  localparam int COMP_A_RESET_BIT = 0;

  // reset values
  localparam logic [7:0] MAIN_CONTROL_RESET = 8'h00;
  localparam logic [7:0] SOURCE_SELECT_RESET = 8'h00;

  // divider: select 0 gives a period of 4, each step doubles it
  localparam int DIVIDER_BASE_LOG2 = 2;
  localparam int DIVIDER_WIDTH = 9;
  localparam logic [8:0] DIVIDER_RESET = 9'h000;

  // register read data width
  localparam int DATA_WIDTH = 8;

endpackage : latch_pkg

// ### pkg/pulse_if.sv
/*
  Interface carrying the divider select into the pulse generator and the
  periodic pulse back out.
  Assumes both ends run on clock_i.
*/
`timescale 1ns/1ps
`default_nettype none

interface pulse_if;
  logic [2:0] divider_select;
  logic pulse;

  modport generator (input divider_select, output pulse);
  modport user (output divider_select, input pulse);
endinterface : pulse_if

`default_nettype wire

// ### verilog/pulse_divider.sv
/*
  Periodic pulse generator: one clock-wide pulse every 4 to 512 cycles.
  Assumes clock_i is the oscillator and the select is a stable register.
*/
`timescale 1ns/1ps
`default_nettype none

module pulse_divider
  import latch_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // select in, pulse out
  pulse_if.generator pulses
);

  logic [8:0] count;
  logic [8:0] next_count;
  logic pulse;
  logic next_pulse;
  logic [8:0] period_mask;

  //////////////////////////////////////////////////////////////////////////
  // free-running counter, pulse when the low bits wrap
  always_comb begin
    period_mask = 9'((10'h004 << pulses.divider_select) - 10'h001);
    next_count = 9'(count + 9'h001);
    next_pulse = ((count & period_mask) == period_mask);
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count <= DIVIDER_RESET;
      pulse <= 1'b0;
    end else begin
      count <= next_count;
      pulse <= next_pulse;
    end
  end

  assign pulses.pulse = pulse;

endmodule : pulse_divider

`default_nettype wire

// ### verilog/set_reset_latch_unit.sv
/*
  Software-controlled set/reset latch with selectable sources and a
  programmable periodic pulse for setting or resetting.
  Assumes a byte-wide register port on clock_i; comparator and pin inputs
  are synchronous to clock_i.
*/
// Design decisions made here: the plain strobed port and the register addresses.
// What this block does
// - divider select gives pulse every 4..512 cycles
// - enable bit 7 gates both output routes
// - bit 3 routes true output to pin
// - bit 2 routes inverted output to pin
// - bit 1 write-one gives set pulse
// - bit 0 write-one gives reset pulse
// - pin-set enable lets input pin set
// - clock-set enable lets divider pulse set
// - comparator B set enable
// - comparator A set enable
// - pin-reset enable lets input pin reset
// - clock-reset enable lets divider pulse reset
// - comparator B reset enable
// - comparator A reset enable
// - reset dominates when both asserted
// - active-high inputs, state kept without clock
`timescale 1ns/1ps
`default_nettype none

module set_reset_latch_unit
  import latch_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input wire logic [0:0] reg_addr_i,
  input wire logic [latch_pkg::DATA_WIDTH-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [latch_pkg::DATA_WIDTH-1:0] reg_rdata_o,
  // latch sources
  input wire logic latch_input_pin_i,
  input wire logic comparator_a_out_i,
  input wire logic comparator_b_out_i,
  // latch outputs
  output logic latch_true_pin_o,
  output logic latch_true_pin_oe_o,
  output logic latch_inverted_pin_o,
  output logic latch_inverted_pin_oe_o,
  output logic latch_state_o
);

  import latch_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // register decode helpers

  // true when a write strobe targets the given offset
  function automatic logic write_hit(input logic [0:0] addr, input logic wr,
                                     input logic [0:0] target);
    return wr && (addr == target);
  endfunction : write_hit

  //////////////////////////////////////////////////////////////////////////
  // control registers

  logic [7:0] main_control;
  logic [7:0] next_main_control;
  logic [7:0] source_select;
  logic [7:0] next_source_select;
  logic fw_set_pulse;
  logic next_fw_set_pulse;
  logic fw_reset_pulse;
  logic next_fw_reset_pulse;
  logic main_hit;
  logic source_hit;

  // the pulse bits are never stored; a write of one makes a one-cycle pulse
  always_comb begin
    main_hit = write_hit(reg_addr_i, reg_write_i, MAIN_CONTROL_ADDR);
    source_hit = write_hit(reg_addr_i, reg_write_i, SOURCE_SELECT_ADDR);
    next_main_control = main_control;
    next_source_select = source_select;
    next_fw_set_pulse = 1'b0;
    next_fw_reset_pulse = 1'b0;
    if (main_hit) begin
      next_main_control = reg_wdata_i & 8'hfc;
      next_fw_set_pulse = reg_wdata_i[FW_SET_BIT];
      next_fw_reset_pulse = reg_wdata_i[FW_RESET_BIT];
    end
    if (source_hit) begin
      next_source_select = reg_wdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      main_control <= MAIN_CONTROL_RESET;
      source_select <= SOURCE_SELECT_RESET;
      fw_set_pulse <= 1'b0;
      fw_reset_pulse <= 1'b0;
    end else begin
      main_control <= next_main_control;
      source_select <= next_source_select;
      fw_set_pulse <= next_fw_set_pulse;
      fw_reset_pulse <= next_fw_reset_pulse;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // periodic pulse source

  pulse_if pulses ();

  assign pulses.divider_select = main_control[DIVIDER_SEL_LSB +: 3];

  pulse_divider u_divider (
    .clock_i (clock_i),
    .rst_i (rst_i),
    .pulses (pulses)
  );

  //////////////////////////////////////////////////////////////////////////
  // set and reset gathering

  logic set_in;
  logic reset_in;

  // each enabled source ORs into its side
  always_comb begin
    set_in = (source_select[PIN_SET_BIT] & latch_input_pin_i)
           | (source_select[CLOCK_SET_BIT] & pulses.pulse)
           | (source_select[COMP_B_SET_BIT] & comparator_b_out_i)
           | (source_select[COMP_A_SET_BIT] & comparator_a_out_i)
           | fw_set_pulse;
    reset_in = (source_select[PIN_RESET_BIT] & latch_input_pin_i)
             | (source_select[CLOCK_RESET_BIT] & pulses.pulse)
             | (source_select[COMP_B_RESET_BIT] & comparator_b_out_i)
             | (source_select[COMP_A_RESET_BIT] & comparator_a_out_i)
             | fw_reset_pulse;
  end

  //////////////////////////////////////////////////////////////////////////
  // latch core
  // the state flop is not cleared by rst_i, so firmware must set or clear
  // it before routing; sampled on clock_i as a synchronous stand-in for the
  // unclocked latch, it simply holds while nothing is asserted

  logic latch_q;
  logic next_latch_q;

  always_comb begin
    next_latch_q = latch_q;
    if (reset_in) begin
      next_latch_q = 1'b0;
    end else if (set_in) begin
      next_latch_q = 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    latch_q <= next_latch_q;
  end

  //////////////////////////////////////////////////////////////////////////
  // output routing and read data

  logic next_true_oe;
  logic next_inverted_oe;
  logic [7:0] next_rdata;

  // routes only count while the latch is enabled; state unknown until set or cleared
  always_comb begin
    next_true_oe = main_control[LATCH_ENABLE_BIT]
                 & main_control[TRUE_ROUTE_BIT];
    next_inverted_oe = main_control[LATCH_ENABLE_BIT]
                     & main_control[INVERTED_ROUTE_BIT];
    next_rdata = 8'h00;
    if (reg_read_i) begin
      next_rdata = (reg_addr_i == MAIN_CONTROL_ADDR) ? main_control : source_select;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      latch_true_pin_oe_o <= 1'b0;
      latch_inverted_pin_oe_o <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else begin
      latch_true_pin_oe_o <= next_true_oe;
      latch_inverted_pin_oe_o <= next_inverted_oe;
      reg_rdata_o <= next_rdata;
    end
  end

  // pin values update on the same edge as the latch, never held by rst_i
  always_ff @(posedge clock_i) begin
    latch_true_pin_o <= next_latch_q;
    latch_inverted_pin_o <= ~next_latch_q;
    latch_state_o <= next_latch_q;
  end

endmodule : set_reset_latch_unit

`default_nettype wire

// ### tb/latch_unit_assertions.sv
/*
  Checker for the set/reset latch unit: bus, routing and latch relations.
  Bound to the top module; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module latch_unit_assertions
  import latch_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // register port
  input wire logic [0:0] reg_addr_i,
  input wire logic [DATA_WIDTH-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [DATA_WIDTH-1:0] reg_rdata_o,
  // sources
  input wire logic latch_input_pin_i,
  input wire logic comparator_a_out_i,
  input wire logic comparator_b_out_i,
  // outputs
  input wire logic latch_true_pin_o,
  input wire logic latch_true_pin_oe_o,
  input wire logic latch_inverted_pin_o,
  input wire logic latch_inverted_pin_oe_o,
  input wire logic latch_state_o
);
  logic [7:0] main;
  logic [7:0] src;
  logic [7:0] cur;
  logic init;
  logic fw_wr_d;
  logic fw_wr;
  logic set_in;
  logic rst_in;
  logic quiet;
  logic [3:0] srcs;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // shadow registers; pulse bits never stick
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      main <= 8'h00;
      src <= 8'h00;
    end else if (reg_write_i && reg_addr_i) begin
      src <= reg_wdata_i;
    end else if (reg_write_i) begin
      main <= reg_wdata_i & 8'hfc;
    end
  end
  // latch has no reset, so its relations wait until a firmware pulse has
  // landed; the pulse reaches the state one edge after the strobe
  always_ff @(posedge clock_i) begin
    fw_wr_d <= fw_wr;
    init <= (init === 1'b1) || fw_wr_d;
  end
  // enabled sources other than the divider
  assign srcs = {latch_input_pin_i, 1'b0, comparator_b_out_i, comparator_a_out_i};
  assign fw_wr = reg_write_i && !reg_addr_i && (reg_wdata_i[1:0] != 2'b00);
  assign set_in = |(src[7:4] & srcs);
  assign rst_in = |(src[3:0] & srcs);
  assign quiet = !src[6] && !src[2];
  assign cur = reg_addr_i ? src : main;
  a_read_data: assert property ($past(reg_read_i) |-> reg_rdata_o == $past(cur))
    else $error("read data wrong");
  a_oe_true: assert property (latch_true_pin_oe_o == ($past(main[7]) && $past(main[3])))
    else $error("true pin enable wrong");
  a_oe_inv: assert property (latch_inverted_pin_oe_o == ($past(main[7]) && $past(main[2])))
    else $error("inverted pin enable wrong");
  a_true_value: assert property (init |-> latch_true_pin_o == latch_state_o)
    else $error("true pin value wrong");
  a_inv_value: assert property (init |-> latch_inverted_pin_o == !latch_state_o)
    else $error("inverted pin value wrong");
  a_latch_next: assert property (
    $past(init) && $past(quiet) && !$past(fw_wr, 2) |->
    latch_state_o == ($past(rst_in) ? 1'b0 : ($past(set_in) ? 1'b1 : $past(latch_state_o))))
    else $error("latch next state wrong");
  a_fw_set: assert property (fw_wr && reg_wdata_i[1:0] == 2'b10 && src[3:0] == 4'h0 |->
    ##2 latch_state_o) else $error("firmware set lost");
  a_fw_reset: assert property (fw_wr && reg_wdata_i[0] |-> ##2 !latch_state_o)
    else $error("firmware reset lost");
endmodule : latch_unit_assertions

bind set_reset_latch_unit latch_unit_assertions latch_unit_assertions_i (.*);
`default_nettype wire

// ### tb/test_set_reset_latch_unit.sv
/*
  Bench for the set/reset latch unit: registers, divider, sources, pins.
  Assumes a 200 MHz clock and the latch_pkg constants.
*/
`timescale 1ns/1ps
`default_nettype none
module test_set_reset_latch_unit;
  import latch_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [0:0] reg_addr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_write_i = 1'b0;
  logic reg_read_i = 1'b0;
  logic latch_input_pin_i = 1'b0;
  logic comparator_a_out_i = 1'b0;
  logic comparator_b_out_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic latch_true_pin_o;
  logic latch_true_pin_oe_o;
  logic latch_inverted_pin_o;
  logic latch_inverted_pin_oe_o;
  logic latch_state_o;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  integer seed = 32'he32a_5c27;
  logic [31:0] r;
  logic [7:0] m = 8'h00;
  logic [7:0] s = 8'h00;
  logic [7:0] so = 8'h00;
  logic q = 1'b1;
  always #2.5 clock_i = ~clock_i;
  set_reset_latch_unit set_reset_latch_unit_i (.*);
  ////////////////////////////////////////
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // expected latch once steady sources and a firmware pulse have acted
  function automatic logic next_q(input logic [7:0] sel, input logic [2:0] in,
                                  input logic [1:0] fw, input logic q0);
    logic [3:0] src;
    src = {in[2], 1'b0, in[1], in[0]};
    if (|(sel[3:0] & src)) return 1'b0;
    if (|(sel[7:4] & src)) return 1'b1;
    if (fw[0]) return 1'b0;
    if (fw[1]) return 1'b1;
    return q0;
  endfunction : next_q
  // one write cycle; shadows track what reads must return
  task wr(input logic a, input logic [7:0] d);
    @(posedge clock_i);
    reg_write_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clock_i);
    reg_write_i <= 1'b0;
    if (a) s = d;
    else m = d & 8'hfc;
  endtask : wr
  task rd(input logic a, input logic [7:0] e);
    @(posedge clock_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_read_i <= 1'b0;
    #1;
    chk("rdata", reg_rdata_o, e);
  endtask : rd
  // cycles up to the next cleared state, bounded
  task wz(output int c);
    c = 0;
    do begin
      @(posedge clock_i);
      #1;
      c++;
    end while (latch_state_o !== 1'b0 && c < 1100);
  endtask : wz
  task test_done;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  // hang guard, well above the longest sequence
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    rd(0, 8'h00);
    rd(1, 8'h00);
    wr(0, 8'h01);
    rd(0, 8'h00);
    chk("state", latch_state_o, 0);
    wr(0, 8'h02);
    rd(0, 8'h00);
    chk("state", latch_state_o, 1);
    wr(0, 8'h8e);
    rd(0, 8'h8c);
    chk("oe", {latch_true_pin_oe_o, latch_inverted_pin_oe_o}, 3);
    chk("pins", {latch_true_pin_o, latch_inverted_pin_o}, 2);
    wr(0, 8'h0c);
    rd(0, 8'h0c);
    chk("oe", {latch_true_pin_oe_o, latch_inverted_pin_oe_o}, 0);
    // comparator holds set, divider pulse wins for one cycle
    wr(1, 8'h14);
    comparator_a_out_i <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      wr(0, {1'b0, 3'(k), 4'h0});
      wz(n);
      wz(n);
      wz(n);
      chk("period", n, 4 << k);
    end
    comparator_a_out_i <= 1'b0;
    wr(1, 8'h40);
    wr(0, 8'h01);
    repeat (6) @(posedge clock_i);
    #1;
    chk("clock set", latch_state_o, 1);
    // random sources and registers; divider enables kept off
    wr(1, 8'hbb);
    wr(0, 8'hfc);
    // mid-run reset clears registers and routes but leaves the latch alone
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    m = 8'h00;
    s = 8'h00;
    rd(0, 8'h00);
    rd(1, 8'h00);
    chk("oe", {latch_true_pin_oe_o, latch_inverted_pin_oe_o}, 0);
    chk("held", latch_state_o, 1);
    repeat (150) begin
      r = $random(seed);
      @(posedge clock_i);
      latch_input_pin_i <= r[8];
      comparator_a_out_i <= r[9];
      comparator_b_out_i <= r[10];
      so = s;
      wr(r[11], r[11] ? r[7:0] & 8'hbb : r[7:0]);
      rd(0, m);
      rd(1, s);
      chk("oe_true", latch_true_pin_oe_o, m[7] & m[3]);
      chk("oe_inv", latch_inverted_pin_oe_o, m[7] & m[2]);
      // new inputs act under the old selection for a few edges first
      q = next_q(so, {r[8], r[10], r[9]}, 2'b00, q);
      q = next_q(s, {r[8], r[10], r[9]}, r[11] ? 2'b00 : r[1:0], q);
      chk("state", latch_state_o, q);
      chk("pins", {latch_true_pin_o, latch_inverted_pin_o}, {q, ~q});
    end
    test_done();
  end
endmodule : test_set_reset_latch_unit
`default_nettype wire
